/* design/asr_receiver.v */
// Asynchronous serial receiver with oversampling recovery, two-entry FIFO and AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.vh"

module asr_receiver (
    input  wire        clk,
    input  wire        rstn,
    input  wire        serial_input_pin,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    reg  [1:0] rst_sync_reg;
    wire       rst_n;
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    reg  [7:0] tx_status_control_reg;
    reg  [7:0] baud_control_reg;
    reg  [7:0] baud_divisor_low_reg;
    reg  [7:0] baud_divisor_high_reg;
    reg        serial_port_enable_reg;
    reg        nine_bit_rx_select_reg;
    reg        continuous_receive_enable_reg;
    reg  [7:0] rsc_spare_reg;
    reg  [2:0] irq_control_reg;
    reg  [2:0] irq_status_reg;
    reg  [2:0] irq_mask_reg;

    wire rx_enable = continuous_receive_enable_reg & serial_port_enable_reg
                   & ~tx_status_control_reg[`ASR_TSC_SYNC_BIT];
    wire async_mode = ~tx_status_control_reg[`ASR_TSC_SYNC_BIT];
    wire rx_polarity_invert = baud_control_reg[`ASR_BC_RX_POL_BIT] & async_mode;

    // ------------------------------------------------------------------------
    // Oversampling tick, sixteen per bit from the baud divisor
    // ------------------------------------------------------------------------
    reg  [15:0] div_cnt_reg;
    wire [15:0] divisor = {baud_divisor_high_reg, baud_divisor_low_reg};
    wire        tick = (div_cnt_reg == 16'h0000);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            div_cnt_reg <= 16'h0000;
        else if (tick || !serial_port_enable_reg)
            div_cnt_reg <= divisor;
        else
            div_cnt_reg <= div_cnt_reg - 16'h0001;
    end

    // ------------------------------------------------------------------------
    // Line conditioning and majority window
    // ------------------------------------------------------------------------
    wire       line = serial_input_pin ^ rx_polarity_invert;
    reg  [2:0] win_reg;
    wire       majority = (win_reg[0] & win_reg[1]) | (win_reg[1] & win_reg[2])
                        | (win_reg[0] & win_reg[2]);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            win_reg <= 3'b111;
        else if (tick)
            win_reg <= {win_reg[1:0], line};
    end

    // ------------------------------------------------------------------------
    // Data recovery state machine
    // ------------------------------------------------------------------------
    localparam ST_HUNT  = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam ST_STOP  = 2'd3;

    reg  [1:0] state_reg;
    reg  [3:0] phase_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [8:0] rx_shift_register;
    reg        prev_line_reg;
    reg        push;
    reg        push_framing_error_flag;
    reg        overrun_error_flag;

    wire [3:0] last_bit = nine_bit_rx_select_reg ? 4'd8 : 4'd7;

    // The window lags the line by one tick, so the centre decision uses the
    // sample at centre minus one, centre and centre plus one.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg         <= ST_HUNT;
            phase_reg         <= 4'h0;
            bit_cnt_reg       <= 4'h0;
            rx_shift_register <= 9'h000;
            prev_line_reg     <= 1'b1;
            push              <= 1'b0;
            push_framing_error_flag         <= 1'b0;
        end else begin
            push <= 1'b0;
            if (tick)
                prev_line_reg <= line;
            if (!rx_enable || overrun_error_flag) begin
                state_reg <= ST_HUNT;
            end else if (tick) begin
                case (state_reg)
                    ST_HUNT: begin
                        if (prev_line_reg && !line) begin
                            state_reg <= ST_START;
                            phase_reg <= 4'h0;
                        end
                    end
                    ST_START: begin
                        phase_reg <= phase_reg + 4'h1;
                        if (phase_reg == `ASR_HALF_BIT_TICKS + 4'h1) begin
                            phase_reg <= 4'h0;
                            bit_cnt_reg <= 4'h0;
                            if (majority)
                                state_reg <= ST_HUNT;
                            else
                                state_reg <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        phase_reg <= phase_reg + 4'h1;
                        if (phase_reg == `ASR_FULL_BIT_TICKS) begin
                            phase_reg <= 4'h0;
                            // Bits enter at the top and move down: LSB first.
                            if (nine_bit_rx_select_reg)
                                rx_shift_register <= {majority, rx_shift_register[8:1]};
                            else
                                rx_shift_register <= {1'b0, majority, rx_shift_register[7:1]};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == last_bit)
                                state_reg <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        phase_reg <= phase_reg + 4'h1;
                        if (phase_reg == `ASR_FULL_BIT_TICKS) begin
                            push      <= 1'b1;
                            push_framing_error_flag <= ~majority;
                            state_reg <= ST_HUNT;
                        end
                    end
                    default: state_reg <= ST_HUNT;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Two-entry receive FIFO with per-entry framing status
    // ------------------------------------------------------------------------
    reg  [8:0] fifo_data [0:1];
    reg  [1:0] fifo_framing_error_flag_reg;
    reg        rd_ptr_reg;
    reg        wr_ptr_reg;
    reg  [1:0] count_reg;
    wire       pop;
    wire       fifo_full = (count_reg == `ASR_FIFO_DEPTH);
    wire       do_push = push && !fifo_full;
    wire       do_pop = pop && (count_reg != 2'b00);
    // An empty FIFO reads as zero, so a never-written entry cannot leak out.
    wire [8:0] head_data = (count_reg != 2'b00) ? fifo_data[rd_ptr_reg] : 9'h000;
    wire       head_framing_error_flag = (count_reg != 2'b00) & fifo_framing_error_flag_reg[rd_ptr_reg];

    always @(posedge clk) begin
        if (do_push)
            fifo_data[wr_ptr_reg] <= rx_shift_register;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_framing_error_flag_reg      <= 2'b00;
            rd_ptr_reg         <= 1'b0;
            wr_ptr_reg         <= 1'b0;
            count_reg          <= 2'b00;
            overrun_error_flag <= 1'b0;
        end else if (!serial_port_enable_reg) begin
            fifo_framing_error_flag_reg      <= 2'b00;
            rd_ptr_reg         <= 1'b0;
            wr_ptr_reg         <= 1'b0;
            count_reg          <= 2'b00;
            overrun_error_flag <= 1'b0;
        end else begin
            if (do_push) begin
                fifo_framing_error_flag_reg[wr_ptr_reg] <= push_framing_error_flag;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (do_pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, do_push} - {1'b0, do_pop};
            if (push && fifo_full)
                overrun_error_flag <= 1'b1;
            else if (!continuous_receive_enable_reg)
                overrun_error_flag <= 1'b0;
        end
    end

    // Flag is pure hardware state; a register write reaches it only by clearing the port enable, which empties the FIFO.
    wire rx_char_available_flag = (count_reg != 2'b00);
    wire irq_gate = irq_control_reg[`ASR_IC_RX_IE_BIT] & irq_control_reg[`ASR_IC_PERIPH_IE_BIT]
                  & irq_control_reg[`ASR_IC_GLOBAL_IE_BIT];

    // ------------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------------
    reg  [7:0]  aw_addr_reg;
    reg         aw_full_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_full_reg;
    wire        wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire        rd_go = s_axi_arvalid && s_axi_arready;
    wire        wr_b0 = wr_go && w_strb_reg[0];
    assign pop = rd_go && (s_axi_araddr == `ASR_RX_DATA_ADDR);

    wire [7:0] rsc_view = {serial_port_enable_reg, nine_bit_rx_select_reg, rsc_spare_reg[5],
                           continuous_receive_enable_reg, rsc_spare_reg[3], head_framing_error_flag,
                           overrun_error_flag, head_data[8]};
    wire [7:0] bc_view = {baud_control_reg[7], (state_reg == ST_HUNT), baud_control_reg[5:0]};

    reg  [31:0] rd_mux;
    reg         rd_ok;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (s_axi_araddr)
            `ASR_TX_STATUS_CONTROL_ADDR: rd_mux[7:0] = tx_status_control_reg;
            `ASR_RX_STATUS_CONTROL_ADDR: rd_mux[7:0] = rsc_view;
            `ASR_BAUD_CONTROL_ADDR:      rd_mux[7:0] = bc_view;
            `ASR_BAUD_DIVISOR_LOW_ADDR:  rd_mux[7:0] = baud_divisor_low_reg;
            `ASR_BAUD_DIVISOR_HIGH_ADDR: rd_mux[7:0] = baud_divisor_high_reg;
            `ASR_RX_DATA_ADDR:           rd_mux[7:0] = head_data[7:0];
            `ASR_IRQ_CONTROL_ADDR:       rd_mux[2:0] = irq_control_reg;
            `ASR_IRQ_STATUS_ADDR:        rd_mux[2:0] = irq_status_reg;
            `ASR_IRQ_MASK_ADDR:          rd_mux[2:0] = irq_mask_reg;
            default:                     rd_ok = 1'b0;
        endcase
    end

    wire [2:0] events = {push & push_framing_error_flag & !fifo_full, push & fifo_full, do_push};
    wire       st_rd = rd_go && (s_axi_araddr == `ASR_IRQ_STATUS_ADDR);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h0000_0000;
            aw_addr_reg   <= 8'h00;
            aw_full_reg   <= 1'b0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            w_full_reg    <= 1'b0;
            irq           <= 1'b0;
            tx_status_control_reg         <= `ASR_RESET_BYTE;
            baud_control_reg              <= `ASR_RESET_BYTE;
            baud_divisor_low_reg          <= `ASR_RESET_BYTE;
            baud_divisor_high_reg         <= `ASR_RESET_BYTE;
            serial_port_enable_reg        <= 1'b0;
            nine_bit_rx_select_reg        <= 1'b0;
            continuous_receive_enable_reg <= 1'b0;
            rsc_spare_reg                 <= `ASR_RESET_BYTE;
            irq_control_reg               <= 3'b000;
            irq_status_reg                <= 3'b000;
            irq_mask_reg                  <= 3'b000;
        end else begin
            s_axi_awready <= !aw_full_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_full_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end
            if (wr_go) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (aw_addr_reg)
                    `ASR_TX_STATUS_CONTROL_ADDR:
                        if (wr_b0) tx_status_control_reg <= w_data_reg[7:0];
                    `ASR_RX_STATUS_CONTROL_ADDR:
                        if (wr_b0) begin
                            serial_port_enable_reg        <= w_data_reg[`ASR_RSC_PORT_EN_BIT];
                            nine_bit_rx_select_reg        <= w_data_reg[`ASR_RSC_NINE_BIT];
                            continuous_receive_enable_reg <= w_data_reg[`ASR_RSC_CONT_RX_BIT];
                            rsc_spare_reg                 <= w_data_reg[7:0];
                        end
                    `ASR_BAUD_CONTROL_ADDR:
                        if (wr_b0) baud_control_reg <= w_data_reg[7:0];
                    `ASR_BAUD_DIVISOR_LOW_ADDR:
                        if (wr_b0) baud_divisor_low_reg <= w_data_reg[7:0];
                    `ASR_BAUD_DIVISOR_HIGH_ADDR:
                        if (wr_b0) baud_divisor_high_reg <= w_data_reg[7:0];
                    `ASR_RX_DATA_ADDR: ;
                    `ASR_IRQ_CONTROL_ADDR:
                        if (wr_b0) irq_control_reg <= w_data_reg[2:0];
                    `ASR_IRQ_STATUS_ADDR: ;
                    `ASR_IRQ_MASK_ADDR:
                        if (wr_b0) irq_mask_reg <= w_data_reg[2:0];
                    default: s_axi_bresp <= 2'b10;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            // Set wins over the read-clear so no event is lost.
            irq_status_reg <= (st_rd ? 3'b000 : irq_status_reg) | events;
            irq <= ((irq_status_reg & irq_mask_reg) != 3'b000)
                 || (rx_char_available_flag && irq_gate);
        end
    end

endmodule // asr_receiver
`default_nettype wire

/* inc/asr_map.vh */
// Register offsets, field positions, reset values and timing counts of the serial receiver.
`ifndef ASR_MAP_VH
`define ASR_MAP_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ASR_TX_STATUS_CONTROL_ADDR   8'h00
`define ASR_RX_STATUS_CONTROL_ADDR   8'h04
`define ASR_BAUD_CONTROL_ADDR        8'h08
`define ASR_BAUD_DIVISOR_LOW_ADDR    8'h0c
`define ASR_BAUD_DIVISOR_HIGH_ADDR   8'h10
`define ASR_RX_DATA_ADDR             8'h14
`define ASR_IRQ_CONTROL_ADDR         8'h18
`define ASR_IRQ_STATUS_ADDR          8'h1c
`define ASR_IRQ_MASK_ADDR            8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ASR_RSC_PORT_EN_BIT          7
`define ASR_RSC_NINE_BIT             6
`define ASR_RSC_CONT_RX_BIT          4
`define ASR_RSC_FRAMING_BIT          2
`define ASR_RSC_OVERRUN_BIT          1
`define ASR_RSC_NINTH_BIT            0
`define ASR_TSC_SYNC_BIT             4
`define ASR_BC_RX_IDLE_BIT           6
`define ASR_BC_RX_POL_BIT            5
`define ASR_IC_RX_IE_BIT             0
`define ASR_IC_PERIPH_IE_BIT         1
`define ASR_IC_GLOBAL_IE_BIT         2
`define ASR_IS_CHAR_BIT              0
`define ASR_IS_OVERRUN_BIT           1
`define ASR_IS_FRAMING_BIT           2

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define ASR_RESET_BYTE               8'h00
`define ASR_OVERSAMPLE               5'h10
`define ASR_HALF_BIT_TICKS           4'h7
`define ASR_FULL_BIT_TICKS           4'hf
`define ASR_FIFO_DEPTH               2'h2

`endif

/* testbench/asr_receiver_monitor.sv */
// Register-port protocol checker for the serial receiver.
`timescale 1ns/1ps
`default_nettype none
module asr_receiver_monitor (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready held");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read address ready held");
    aw_answer_a: assert property ($rose(s_axi_awvalid) |-> ##[1:2] s_axi_awready)
        else $error("write address not taken");
    b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wready, 2))
        else $error("write response without data");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
endmodule // asr_receiver_monitor

bind asr_receiver asr_receiver_monitor u_mon (
    .clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
`default_nettype wire

/* testbench/asr_line_model.sv */
// Remote asynchronous transmitter driving the receive line.
`timescale 1ns/1ps
`default_nettype none
module asr_line_model #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic clk,
    output var  logic line
);
    logic inv = 1'b0;
    initial line = 1'b1;
    task automatic put(input logic b, input int n);
        line <= b ^ inv;
        repeat (n) @(posedge clk);
    endtask
    // A low stop cell models a framing fault; idle cells model a slow sender.
    task automatic send(input logic [8:0] d, input logic nine, input logic stop_ok, input int idle);
        put(1'b0, BIT_CLKS);
        for (int i = 0; i < (nine ? 9 : 8); i++) put(d[i], BIT_CLKS);
        put(stop_ok, BIT_CLKS);
        put(1'b1, BIT_CLKS * idle);
    endtask
endmodule // asr_line_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the serial receiver.
`timescale 1ns/1ps
`default_nettype none
`include "asr_map.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    localparam int BIT = 64;
    logic        clk = 0, rstn = 0, irq, line;
    logic [7:0]  awaddr = 0, araddr = 0, b;
    logic [31:0] wdata = 0, rdata, lr;
    logic        awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic        arvalid = 0, arready, rvalid, rready = 0, f;
    logic [1:0]  bresp, rresp, lresp;
    logic [8:0]  c [3];
    int          mismatches = 0, num_checks = 0, cyc = 0;

    asr_line_model #(.BIT_CLKS(BIT)) u_tx (.clk(clk), .line(line));
    asr_receiver u_dut (.clk(clk), .rstn(rstn), .serial_input_pin(line),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end

    // ----------------------------------------------------------------
    // Bus tasks and expectations
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic aw = 1, w = 1;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && awready) begin aw = 0; awvalid <= 0; end
            if (w && wready) begin w = 0; wvalid <= 0; end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        lresp = bresp;
        bready <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge clk);
        lr = rdata;
        lresp = rresp;
        rready <= 0;
        @(posedge clk);
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CHK(lr, e)
    endtask
    function automatic logic [31:0] rsc(input logic fe, ov, d8, input logic [7:0] base);
        return {24'h0, base | {5'h0, fe, ov, d8}};
    endfunction
    function automatic logic exp_irq(input logic [2:0] ctl);
        return ctl == 3'h7;
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(16091));
        repeat (10) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        // The receiver idle bit of the baud control register reads 1 while hunting.
        for (int a = 0; a <= 32; a += 4) if (a != 20) ck(a[7:0], a == 8 ? 32'h40 : 32'h0);
        rd(8'h24);
        `CHK(lresp, 2'b10)
        wr(8'h24, 8'h55);
        `CHK(lresp, 2'b10)
        wr(`ASR_BAUD_DIVISOR_LOW_ADDR, 8'h03);
        `CHK(lresp, 2'b00)
        ck(`ASR_BAUD_DIVISOR_LOW_ADDR, 32'h3);
        $display("test registers done");
        wr(`ASR_IRQ_MASK_ADDR, 8'h07);
        wr(`ASR_IRQ_CONTROL_ADDR, 8'h07);
        wr(`ASR_RX_STATUS_CONTROL_ADDR, 8'h90);
        for (int i = 0; i < 4; i++) begin
            b = $urandom;
            f = (i == 1) | $urandom_range(1);
            u_tx.send({1'b0, b}, 0, !f, 1 + $urandom_range(2));
            `CHK(irq, 1'b1)
            ck(`ASR_RX_STATUS_CONTROL_ADDR, rsc(f, 0, 0, 8'h90));
            ck(`ASR_RX_DATA_ADDR, {24'h0, b});
            ck(`ASR_IRQ_STATUS_ADDR, {29'h0, f, 2'b01});
            repeat (2) @(posedge clk);
            `CHK(irq, 1'b0)
        end
        $display("test receive done");
        foreach (c[k]) c[k] = $urandom;
        foreach (c[k]) u_tx.send(c[k], 0, k != 0, 1);
        ck(`ASR_RX_STATUS_CONTROL_ADDR, rsc(1, 1, 0, 8'h90));
        ck(`ASR_RX_DATA_ADDR, {24'h0, c[0][7:0]});
        ck(`ASR_RX_STATUS_CONTROL_ADDR, rsc(0, 1, 0, 8'h90));
        ck(`ASR_RX_DATA_ADDR, {24'h0, c[1][7:0]});
        ck(`ASR_IRQ_STATUS_ADDR, 32'h7);
        u_tx.send(9'h0a5, 0, 1, 1);
        ck(`ASR_IRQ_STATUS_ADDR, 32'h0);
        wr(`ASR_RX_STATUS_CONTROL_ADDR, 8'h80);
        wr(`ASR_RX_STATUS_CONTROL_ADDR, 8'h90);
        ck(`ASR_RX_STATUS_CONTROL_ADDR, 32'h90);
        $display("test fifo done");
        u_tx.put(1'b0, BIT / 4);
        u_tx.put(1'b1, 2 * BIT);
        ck(`ASR_IRQ_STATUS_ADDR, 32'h0);
        $display("test glitch done");
        wr(`ASR_RX_STATUS_CONTROL_ADDR, 8'h80);
        wr(`ASR_BAUD_CONTROL_ADDR, 8'h20);
        u_tx.inv = 1'b1;
        u_tx.put(1'b1, BIT);
        wr(`ASR_RX_STATUS_CONTROL_ADDR, 8'h90);
        b = $urandom;
        u_tx.send({1'b0, b}, 0, 1, 1);
        ck(`ASR_RX_DATA_ADDR, {24'h0, b});
        wr(`ASR_RX_STATUS_CONTROL_ADDR, 8'hd0);
        c[0] = $urandom;
        u_tx.send(c[0], 1, 1, 1);
        ck(`ASR_RX_STATUS_CONTROL_ADDR, rsc(0, 0, c[0][8], 8'hd0));
        ck(`ASR_RX_DATA_ADDR, {24'h0, c[0][7:0]});
        rd(`ASR_IRQ_STATUS_ADDR);
        $display("test polarity and nine bit done");
        for (int k = 0; k < 3; k++) begin
            wr(`ASR_TX_STATUS_CONTROL_ADDR, k == 0 ? 8'h10 : 8'h00);
            wr(`ASR_RX_STATUS_CONTROL_ADDR, k == 1 ? 8'h80 : k == 2 ? 8'h10 : 8'h90);
            u_tx.send({1'b0, 8'h3c}, 0, 1, 1);
            ck(`ASR_IRQ_STATUS_ADDR, 32'h0);
        end
        wr(`ASR_TX_STATUS_CONTROL_ADDR, 8'h00);
        wr(`ASR_RX_STATUS_CONTROL_ADDR, 8'h90);
        $display("test enables done");
        wr(`ASR_IRQ_MASK_ADDR, 8'h00);
        u_tx.send({1'b0, 8'h96}, 0, 1, 1);
        for (int k = 0; k < 8; k++) begin
            wr(`ASR_IRQ_CONTROL_ADDR, k[7:0]);
            repeat (2) @(posedge clk);
            `CHK(irq, exp_irq(k[2:0]))
        end
        wr(`ASR_RX_DATA_ADDR, 8'h00);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        ck(`ASR_IRQ_STATUS_ADDR, 32'h1);
        ck(`ASR_RX_DATA_ADDR, 32'h96);
        $display("test interrupt done");
        results();
    end
endmodule // tb
`default_nettype wire
